// ==== drive_model.sv ====
// Purpose: drive model that ramps the output frequency up and down
// Assumes: ramp length in cycles set by the bench
// Notes:   ramp kept shorter than one second of run time
module drive_model (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       drive_run_cmd,
    input  wire [3:0] ramp,
    output wire       output_at_zero
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] speed_reg;
    // coasts down whenever run is withdrawn, stop or not
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) speed_reg <= 4'h0;
        else if (drive_run_cmd && speed_reg < ramp) speed_reg <= speed_reg + 4'h1;
        else if (!drive_run_cmd && speed_reg != 4'h0) speed_reg <= speed_reg - 4'h1;
    end
    assign output_at_zero = (speed_reg == 4'h0);
endmodule // drive_model

// ==== fixed_frequency_sequencer.v ====
// Purpose: step sequencer over eight fixed-frequency setpoints
// Assumes: inputs synchronous to hclk, AHB-Lite single word transfers
// Notes:   drive outputs lag the internal state by one edge
`include "fixed_frequency_sequencer_map.vh"
module fixed_frequency_sequencer #(
    parameter TICKS_PER_SEC = `SEQ_TICKS_PER_SEC,
    parameter RT_WIDTH      = 10,
    parameter STEPS         = 8
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    input  wire [5:0]  digital_command_inputs,
    input  wire        ext_start_cmd,
    input  wire        output_at_zero,
    output reg         drive_run_cmd,
    output reg         stop_function,
    output reg         setpoint_from_sequencer,
    output reg  [2:0]  fixed_freq_step,
    output reg         reverse_rotation
);
    localparam ST_IDLE = 3'h0;
    localparam ST_RUN  = 3'h1;
    localparam ST_HALT = 3'h2;
    localparam ST_DONE = 3'h3;
    localparam [31:0] TICK_LAST = TICKS_PER_SEC - 1;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function pick_input;
        input [5:0] di;
        input [2:0] sel;
        begin
            if (sel == `SEQ_SEL_NONE || sel > 3'h6)
                pick_input = 1'b0;
            else
                pick_input = di[sel - 3'h1];
        end
    endfunction

    // lowest active step at or above from, {found, index}
    function [3:0] first_active;
        input [7:0] mask;
        input [3:0] from;
        integer k;
        begin
            first_active = 4'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (mask[k] && k >= from)
                    first_active = {1'b1, k[2:0]};
            end
        end
    endfunction

    function is_run_time;
        input [7:0] a;
        begin
            is_run_time = (a >= `SEQ_ADDR_RT_FIRST) && (a <= `SEQ_ADDR_RT_LAST)
                          && (a[1:0] == 2'h0);
        end
    endfunction

    // ****************************************************************
    // bus slave
    // ****************************************************************
    reg        dp_valid_reg;
    reg        dp_write_reg;
    reg [7:0]  dp_addr_reg;
    reg        rd_wait_reg;
    reg [31:0] hrdata_reg;
    reg [2:0]  mode_reg;
    reg [7:0]  direction_reg;
    reg [2:0]  start_sel_reg;
    reg [2:0]  pause_sel_reg;
    reg [7:0]  active_mask_reg;
    reg [2:0]  step_reg;
    wire [RT_WIDTH-1:0] bus_rt;
    wire [RT_WIDTH-1:0] step_rt;
    wire [31:0] status_word;
    wire        wr_phase = dp_valid_reg && dp_write_reg;
    wire        dp_is_rt = is_run_time(dp_addr_reg);
    wire [2:0]  dp_rt_idx = dp_addr_reg[4:2] - `SEQ_RT_INDEX_BIAS;
    wire [15:0] wr_low = hwdata[15:0];
    // oversized run times saturate rather than wrap
    wire [RT_WIDTH-1:0] rt_clamped = ((|hwdata[31:16]) || (wr_low > {6'h00, `SEQ_RT_MAX})) ?
                                     `SEQ_RT_MAX : wr_low[RT_WIDTH-1:0];
    wire        rt_wr = wr_phase && dp_is_rt;

    // one wait state on reads so a write just before is always seen
    assign hreadyout = !(dp_valid_reg && !dp_write_reg && rd_wait_reg);
    assign hresp     = 1'b0;
    assign hrdata    = dp_is_rt ? {{(32-RT_WIDTH){1'b0}}, bus_rt} : hrdata_reg;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= 8'h00;
            rd_wait_reg  <= 1'b0;
            hrdata_reg   <= 32'h0000_0000;
        end else begin
            if (hready) begin
                dp_valid_reg <= hsel && htrans[1];
                dp_write_reg <= hwrite;
                dp_addr_reg  <= haddr[7:0];
                rd_wait_reg  <= hsel && htrans[1] && !hwrite;
            end else begin
                rd_wait_reg  <= 1'b0;
            end
            if (rd_wait_reg) begin
                case (dp_addr_reg)
                    `SEQ_ADDR_MODE:      hrdata_reg <= {29'h0, mode_reg};
                    `SEQ_ADDR_DIRECTION: hrdata_reg <= {24'h0, direction_reg};
                    `SEQ_ADDR_INPUT_SEL: hrdata_reg <= {25'h0, pause_sel_reg,
                                                        1'b0, start_sel_reg};
                    `SEQ_ADDR_STATUS:    hrdata_reg <= status_word;
                    default:             hrdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg        <= `SEQ_MODE_RESET;
            direction_reg   <= `SEQ_DIR_RESET;
            start_sel_reg   <= `SEQ_SEL_RESET;
            pause_sel_reg   <= `SEQ_SEL_RESET;
            active_mask_reg <= 8'h00;
        end else if (wr_phase) begin
            case (dp_addr_reg)
                `SEQ_ADDR_MODE:      mode_reg      <= hwdata[2:0];
                `SEQ_ADDR_DIRECTION: direction_reg <= hwdata[7:0];
                `SEQ_ADDR_INPUT_SEL: begin
                    start_sel_reg <= hwdata[`SEQ_SEL_START_LSB +: 3];
                    pause_sel_reg <= hwdata[`SEQ_SEL_PAUSE_LSB +: 3];
                end
                default: begin
                    if (dp_is_rt)
                        active_mask_reg[dp_rt_idx] <= (rt_clamped != `SEQ_RT_RESET);
                end
            endcase
        end
    end

    run_time_store #(
        .WIDTH     (RT_WIDTH),
        .DEPTH     (STEPS),
        .AW        (3)
    ) u_store (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .wr_en     (rt_wr),
        .wr_addr   (dp_rt_idx),
        .wr_data   (rt_clamped),
        .rd_a_addr (dp_rt_idx),
        .rd_a_data (bus_rt),
        .rd_b_addr (step_reg),
        .rd_b_data (step_rt)
    );

    // ****************************************************************
    // sequence control
    // ****************************************************************
    reg  [2:0]  state_reg;
    reg  [31:0] tick_reg;
    reg  [RT_WIDTH-1:0] sec_reg;
    wire start_lvl  = pick_input(digital_command_inputs, start_sel_reg);
    wire pause_lvl  = pick_input(digital_command_inputs, pause_sel_reg);
    wire seq_en     = (mode_reg >= `SEQ_MODE_ONCE) && (mode_reg <= `SEQ_MODE_CONT_STEP);
    wire continuous = (mode_reg == `SEQ_MODE_CONT) || (mode_reg == `SEQ_MODE_CONT_STEP);
    wire stepped    = (mode_reg == `SEQ_MODE_ONCE_STEP) ||
                      (mode_reg == `SEQ_MODE_CONT_STEP);
    wire tick_end   = (tick_reg == TICK_LAST);
    wire [RT_WIDTH:0] sec_plus = {1'b0, sec_reg} + {{RT_WIDTH{1'b0}}, 1'b1};
    // compared only at a second boundary, so the store's read lag is harmless
    wire expired    = tick_end && (sec_plus >= {1'b0, step_rt});
    wire [3:0] from_next = {1'b0, step_reg} + 4'h1;
    wire [3:0] nxt_hit   = first_active(active_mask_reg, from_next);
    wire [3:0] wrap_hit  = first_active(active_mask_reg, 4'h0);

    assign status_word = {23'h0, start_lvl, direction_reg[step_reg], step_reg,
                          (state_reg == ST_DONE), (state_reg == ST_HALT),
                          (state_reg == ST_RUN) && pause_lvl,
                          (state_reg == ST_RUN) || (state_reg == ST_HALT)};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            step_reg  <= 3'h0;
            tick_reg  <= 32'h0000_0000;
            sec_reg   <= {RT_WIDTH{1'b0}};
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // level start: a held input starts again once mode and start select enable it
                    if (seq_en && start_lvl) begin
                        tick_reg <= 32'h0000_0000;
                        sec_reg  <= {RT_WIDTH{1'b0}};
                        if (wrap_hit[3]) begin
                            step_reg  <= wrap_hit[2:0];
                            state_reg <= ST_RUN;
                        end else begin
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_RUN: begin
                    if (!seq_en || !start_lvl) begin
                        state_reg <= ST_IDLE;
                    end else if (pause_lvl) begin
                        state_reg <= ST_RUN;
                    end else if (expired) begin
                        tick_reg <= 32'h0000_0000;
                        sec_reg  <= {RT_WIDTH{1'b0}};
                        if (stepped) begin
                            state_reg <= ST_HALT;
                        end else if (nxt_hit[3]) begin
                            step_reg <= nxt_hit[2:0];
                        end else if (continuous && wrap_hit[3]) begin
                            step_reg <= wrap_hit[2:0];
                        end else begin
                            state_reg <= ST_DONE;
                        end
                    end else if (tick_end) begin
                        tick_reg <= 32'h0000_0000;
                        sec_reg  <= sec_plus[RT_WIDTH-1:0];
                    end else begin
                        tick_reg <= tick_reg + 32'h0000_0001;
                    end
                end
                ST_HALT: begin
                    if (!seq_en || !start_lvl) begin
                        state_reg <= ST_IDLE;
                    end else if (output_at_zero) begin
                        if (nxt_hit[3]) begin
                            step_reg  <= nxt_hit[2:0];
                            state_reg <= ST_RUN;
                        end else if (continuous && wrap_hit[3]) begin
                            step_reg  <= wrap_hit[2:0];
                            state_reg <= ST_RUN;
                        end else begin
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    if (!seq_en || !start_lvl)
                        state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // drive outputs
    // ****************************************************************
    // sequencer owns the run command once enabled with a start input chosen
    wire seq_owns = seq_en && (start_sel_reg != `SEQ_SEL_NONE);
    wire seq_live = (state_reg == ST_RUN) || (state_reg == ST_HALT);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_run_cmd           <= 1'b0;
            stop_function           <= 1'b0;
            setpoint_from_sequencer <= 1'b0;
            fixed_freq_step         <= 3'h0;
            reverse_rotation        <= 1'b0;
        end else begin
            drive_run_cmd           <= seq_owns ? (state_reg == ST_RUN) : ext_start_cmd;
            stop_function           <= seq_owns && !(state_reg == ST_RUN);
            setpoint_from_sequencer <= seq_owns && seq_live;
            fixed_freq_step         <= step_reg;
            reverse_rotation        <= direction_reg[step_reg];
        end
    end
endmodule // fixed_frequency_sequencer

// ==== fixed_frequency_sequencer_asserts.sv ====
// Purpose: port-level assertions for the fixed-frequency sequencer
// Assumes: one AHB-Lite slave, hready tied to hreadyout
// Notes:   bound into every instance of the top module
module fixed_frequency_sequencer_asserts (
    input wire       hclk,
    input wire       hresetn,
    input wire       hsel,
    input wire [1:0] htrans,
    input wire       hwrite,
    input wire       hready,
    input wire       hreadyout,
    input wire       hresp,
    input wire       output_at_zero,
    input wire       drive_run_cmd,
    input wire       stop_function,
    input wire       setpoint_from_sequencer,
    input wire [2:0] fixed_freq_step
);
    // ****
    // bus and sequencer properties
    // ****
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire req = hsel && hready && htrans[1];
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_write_no_wait: assert property (req && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_read_one_wait: assert property (req && !hwrite |=> !hreadyout)
        else $error("read data phase without wait");
    a_wait_single: assert property (!hreadyout |=> hreadyout)
        else $error("more than one wait state");
    a_stop_no_run: assert property (stop_function |-> !drive_run_cmd)
        else $error("run and stop both high");
    a_setpoint_run: assert property (setpoint_from_sequencer && !stop_function |-> drive_run_cmd)
        else $error("setpoint owned without run");
    // a step may not end within six cycles after it begins
    a_step_hold: assert property ($changed(fixed_freq_step) && setpoint_from_sequencer
        && $past(setpoint_from_sequencer) |=> ($stable(fixed_freq_step)
        || !setpoint_from_sequencer) [*6])
        else $error("step left too early");
    a_halt_zero: assert property ($fell(stop_function) && setpoint_from_sequencer
        && $past(setpoint_from_sequencer) |-> $past(output_at_zero)
        || $past(output_at_zero, 2))
        else $error("halt left before output at zero");
    c_stop: cover property ($rose(stop_function));
    c_step: cover property ($changed(fixed_freq_step) && setpoint_from_sequencer);
    c_read: cover property (!hreadyout);
endmodule // fixed_frequency_sequencer_asserts

bind fixed_frequency_sequencer fixed_frequency_sequencer_asserts u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .output_at_zero(output_at_zero),
    .drive_run_cmd(drive_run_cmd), .stop_function(stop_function),
    .setpoint_from_sequencer(setpoint_from_sequencer), .fixed_freq_step(fixed_freq_step));

// ==== fixed_frequency_sequencer_map.vh ====
// Purpose: constants for the fixed-frequency sequencer
// Assumes: 32-bit AHB-Lite register words, byte addresses below
// Notes:   included by the main design file and the bench
`ifndef FIXED_FREQUENCY_SEQUENCER_MAP_VH
`define FIXED_FREQUENCY_SEQUENCER_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SEQ_ADDR_MODE        8'h00
`define SEQ_ADDR_DIRECTION   8'h04
`define SEQ_ADDR_INPUT_SEL   8'h08
`define SEQ_ADDR_STATUS      8'h0c
`define SEQ_ADDR_RT_FIRST    8'h10
`define SEQ_ADDR_RT_LAST     8'h2c
`define SEQ_RT_INDEX_BIAS    3'h4

// ****************************************************************
// fields and reset values
// ****************************************************************
`define SEQ_MODE_OFF         3'h0
`define SEQ_MODE_ONCE        3'h1
`define SEQ_MODE_CONT        3'h2
`define SEQ_MODE_ONCE_STEP   3'h3
`define SEQ_MODE_CONT_STEP   3'h4
`define SEQ_MODE_RESET       3'h0
`define SEQ_DIR_RESET        8'h00
`define SEQ_SEL_RESET        3'h0
`define SEQ_SEL_NONE         3'h0
`define SEQ_SEL_START_LSB    0
`define SEQ_SEL_PAUSE_LSB    4
`define SEQ_RT_RESET         10'h000
`define SEQ_RT_MAX           10'h3e8
`define SEQ_ST_RUNNING       0
`define SEQ_ST_PAUSED        1
`define SEQ_ST_STOPPING      2
`define SEQ_ST_DONE          3
`define SEQ_ST_STEP_LSB      4
`define SEQ_ST_REVERSE       7
`define SEQ_ST_START         8

// ****************************************************************
// timing
// ****************************************************************
`define SEQ_CLK_HZ           200000000
`define SEQ_SECOND_S         1
`define SEQ_TICKS_PER_SEC    (`SEQ_CLK_HZ * `SEQ_SECOND_S)

`endif

// ==== fixed_frequency_sequencer_tb.sv ====
// Purpose: self-checking bench for the fixed-frequency sequencer
// Assumes: one AHB-Lite master, drive model on the far side
// Notes:   one second shortened to 8 cycles
`include "fixed_frequency_sequencer_map.vh"
module fixed_frequency_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TPS = 8;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    logic [1:0]  htrans = 2'h0;
    logic [5:0]  di = 6'h00;
    logic [3:0]  ramp = 4'h1;
    logic        ext_start_cmd = 1'b0, hreadyout, hresp, output_at_zero;
    logic        drive_run_cmd, stop_function, setpoint_from_sequencer, reverse_rotation;
    logic [2:0]  fixed_freq_step;
    int          n_errors = 0, samples_checked = 0;
    always #2.5 hclk = ~hclk;
    fixed_frequency_sequencer #(.TICKS_PER_SEC(TPS)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .digital_command_inputs(di), .ext_start_cmd(ext_start_cmd),
        .output_at_zero(output_at_zero), .drive_run_cmd(drive_run_cmd),
        .stop_function(stop_function), .setpoint_from_sequencer(setpoint_from_sequencer),
        .fixed_freq_step(fixed_freq_step), .reverse_rotation(reverse_rotation));
    drive_model drv (.hclk(hclk), .hresetn(hresetn), .drive_run_cmd(drive_run_cmd),
        .ramp(ramp), .output_at_zero(output_at_zero));
    // ****
    // tasks
    // ****
    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // waits for the address phase and the data phase to be accepted
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        v = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(v & m, e);
    endtask
    // cyc of zero only waits for the step; imm demands no gap before it
    task automatic expect_step(input logic [2:0] s, input logic r, input int cyc,
                               input logic imm);
        int w;
        int n;
        w = 0;
        n = 0;
        // setpoint too: a run from the other start source must not pass for a step
        while (!(fixed_freq_step === s && drive_run_cmd === 1'b1
                 && setpoint_from_sequencer === 1'b1) && w < 500) begin
            w++;
            @(posedge hclk);
        end
        if (imm) check(w, 0);
        check({setpoint_from_sequencer, reverse_rotation, fixed_freq_step}, {1'b1, r, s});
        while (cyc != 0 && fixed_freq_step === s && drive_run_cmd === 1'b1) begin
            n++;
            @(posedge hclk);
        end
        if (cyc != 0) check(n, cyc);
    endtask
    task automatic restart(input logic [31:0] m);
        di <= 6'h00;
        wr(`SEQ_ADDR_MODE, m);
        di <= 6'h02;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        report_and_stop();
    end
    // ****
    // scenarios
    // ****
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 13; i++) rd_chk(8'(i * 4), 32'hffffffff, 32'h0);
        wr(`SEQ_ADDR_RT_LAST, 32'h3e9);
        rd_chk(`SEQ_ADDR_RT_LAST, 32'hffffffff, 32'h3e8);
        wr(`SEQ_ADDR_RT_LAST, 32'h10001);
        rd_chk(`SEQ_ADDR_RT_LAST, 32'hffffffff, 32'h3e8);
        wr(`SEQ_ADDR_DIRECTION, 32'hff);
        rd_chk(`SEQ_ADDR_DIRECTION, 32'hffffffff, 32'hff);
        ext_start_cmd <= 1'b1;
        for (int k = 1; k < 7; k++) begin
            wr(`SEQ_ADDR_INPUT_SEL, k);
            di <= 6'(1 << (k - 1));
            rd_chk(`SEQ_ADDR_STATUS, 32'h101, 32'h100);
            di <= ~6'(1 << (k - 1));
            rd_chk(`SEQ_ADDR_STATUS, 32'h101, 32'h0);
            check(drive_run_cmd, 1'b1);
        end
        wr(`SEQ_ADDR_RT_FIRST, 32'h1);
        wr(`SEQ_ADDR_RT_FIRST + 8'h08, 32'h2);
        wr(`SEQ_ADDR_RT_LAST, 32'h1);
        wr(`SEQ_ADDR_DIRECTION, 32'h84);
        wr(`SEQ_ADDR_INPUT_SEL, 32'h52);
        restart(32'h1);
        expect_step(3'h0, 1'b0, TPS, 1'b0);
        expect_step(3'h2, 1'b1, 2 * TPS, 1'b1);
        expect_step(3'h7, 1'b1, TPS, 1'b1);
        repeat (2) @(posedge hclk);
        check(drive_run_cmd, 1'b0);
        rd_chk(`SEQ_ADDR_STATUS, 32'h9, 32'h8);
        restart(32'h2);
        expect_step(3'h0, 1'b0, TPS, 1'b0);
        fork
            expect_step(3'h2, 1'b1, 2 * TPS + 20, 1'b1);
            begin
                repeat (4) @(posedge hclk);
                di[4] <= 1'b1;
                repeat (20) @(posedge hclk);
                di[4] <= 1'b0;
            end
        join
        expect_step(3'h7, 1'b1, TPS, 1'b1);
        expect_step(3'h0, 1'b0, TPS, 1'b1);
        expect_step(3'h2, 1'b1, 0, 1'b1);
        repeat (5) @(posedge hclk);
        di <= 6'h00;
        repeat (3) @(posedge hclk);
        check(drive_run_cmd, 1'b0);
        rd_chk(`SEQ_ADDR_STATUS, 32'h1, 32'h0);
        di <= 6'h02;
        expect_step(3'h0, 1'b0, TPS, 1'b0);
        for (int k = 1; k < 7; k++) begin
            wr(`SEQ_ADDR_INPUT_SEL, (k << 4) | (k == 1 ? 2 : 1));
            di <= 6'(1 << (k - 1)) | (k == 1 ? 6'h02 : 6'h01);
            rd_chk(`SEQ_ADDR_STATUS, 32'h3, 32'h3);
            di <= ~6'(1 << (k - 1));
            rd_chk(`SEQ_ADDR_STATUS, 32'h3, 32'h1);
        end
        wr(`SEQ_ADDR_INPUT_SEL, 32'h52);
        ramp <= 4'h5;
        restart(32'h3);
        expect_step(3'h0, 1'b0, TPS, 1'b0);
        check({drive_run_cmd, stop_function}, 2'b01);
        expect_step(3'h2, 1'b1, 2 * TPS, 1'b0);
        check({drive_run_cmd, stop_function}, 2'b01);
        expect_step(3'h7, 1'b1, TPS, 1'b0);
        ramp <= 4'h1;
        restart(32'h4);
        expect_step(3'h0, 1'b0, TPS, 1'b0);
        expect_step(3'h2, 1'b1, 2 * TPS, 1'b0);
        expect_step(3'h7, 1'b1, TPS, 1'b0);
        expect_step(3'h0, 1'b0, TPS, 1'b0);
        for (int m = 4; m < 8; m++) begin
            wr(`SEQ_ADDR_MODE, (m == 4) ? 0 : m);
            rd_chk(`SEQ_ADDR_STATUS, 32'h1, 32'h0);
            check({drive_run_cmd, setpoint_from_sequencer}, 2'b10);
        end
        report_and_stop();
    end
endmodule // fixed_frequency_sequencer_tb

// ==== run_time_store.v ====
// Purpose: eight run-time words, one write port, two registered read ports
// Assumes: single clock, asynchronous active-low reset
// Notes:   read data appear one edge after the address
module run_time_store #(
    parameter WIDTH = 10,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    input  wire [AW-1:0]    rd_a_addr,
    output reg  [WIDTH-1:0] rd_a_data,
    input  wire [AW-1:0]    rd_b_addr,
    output reg  [WIDTH-1:0] rd_b_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    integer i;

    // ****************************************************************
    // storage, all steps off after reset
    // ****************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {WIDTH{1'b0}};
            end
            rd_a_data <= {WIDTH{1'b0}};
            rd_b_data <= {WIDTH{1'b0}};
        end else begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_a_data <= mem[rd_a_addr];
            rd_b_data <= mem[rd_b_addr];
        end
    end
endmodule // run_time_store
